//--- design/usrt_pkg.sv
/*
 * usrt_pkg: register offsets, bit positions, reset values and
 * fifo depth of the serial port block.
 * assumes a 100 MHz system clock and a wishbone byte-wide map.
 */
package usrt_pkg;
    // printed offsets are not all multiples of four: byte address = 4*index
    localparam logic [7:0] IDX_INTCTL = 8'h0B;
    localparam logic [7:0] IDX_PFLAGS = 8'h0C;
    localparam logic [7:0] IDX_RXSC = 8'h18;
    localparam logic [7:0] IDX_TXHOLD = 8'h19;
    localparam logic [7:0] IDX_RXDATA = 8'h1A;
    localparam logic [7:0] IDX_PENA = 8'h8C;
    localparam logic [7:0] IDX_TXSC = 8'h98;
    localparam logic [7:0] IDX_BAUD = 8'h99;
    // receive_status_control bits
    localparam int RX_PORT_EN = 7;
    localparam int RX_NINE = 6;
    localparam int RX_SINGLE = 5;
    localparam int RX_CONT = 4;
    localparam int RX_ADDR_DET = 3;
    localparam int RX_FRAME = 2;
    localparam int RX_OVERRUN = 1;
    localparam int RX_NINTH = 0;
    // transmit_status_control bits
    localparam int TX_CLK_SRC = 7;
    localparam int TX_NINE = 6;
    localparam int TX_EN = 5;
    localparam int TX_SYNC = 4;
    localparam int TX_HI_SPEED = 2;
    localparam int TX_SH_EMPTY = 1;
    localparam int TX_NINTH = 0;
    // peripheral flag / enable bits
    localparam int PF_RX_FULL = 5;
    localparam int PF_TX_EMPTY = 4;
    // interrupt_control bits
    localparam int IC_GLOBAL = 7;
    localparam int IC_PERIPH = 6;
    localparam logic [7:0] TXSC_RESET = 8'h02;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int FIFO_DEPTH = 2;
endpackage

//--- design/usrt_rx_fifo.sv
/*
 * usrt_rx_fifo: small receive memory of words with registered read
 * data; head word always visible on rd_data.
 * assumes the writer never pushes while full.
 */
`timescale 1ns/10ps
module usrt_rx_fifo
    import usrt_pkg::*;
#(
    parameter int WIDTH = 10
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clear,
    // write side
    input wire logic push,
    input wire logic [WIDTH-1:0] wr_data,
    // read side
    input wire logic pop,
    output logic [WIDTH-1:0] rd_data,
    output logic [1:0] count
);
    logic [WIDTH-1:0] mem_q [FIFO_DEPTH];
    logic rd_ptr_q;
    logic wr_ptr_q;

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || clear)
        begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            count <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop && count != 2'h0)
            begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count <= count + {1'b0, push} -
                {1'b0, pop && count != 2'h0};
        end
    end

    // head word registered; a push into an empty fifo shows next cycle
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            rd_data <= '0;
        end
        else if (push && (count == 2'h0 ||
                 (count == 2'h1 && pop)))
        begin
            rd_data <= wr_data;
        end
        else if (pop && count == 2'h2)
        begin
            rd_data <= mem_q[~rd_ptr_q];
        end
    end
endmodule

//--- design/usrt_baud.sv
/*
 * usrt_baud: divider making one-cycle rate ticks from the system clock.
 * assumes divisor is stable while running.
 */
`timescale 1ns/10ps
module usrt_baud
    import usrt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // control
    input wire logic run,
    input wire logic [7:0] divisor,
    // tick out
    output logic tick
);
    logic [7:0] cnt_q;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !run)
        begin
            cnt_q <= 8'h00;
            tick <= 1'b0;
        end
        else if (cnt_q >= divisor)
        begin
            cnt_q <= 8'h00;
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule

//--- design/usrt_top.sv
/*
 * usrt_top: serial port with asynchronous receive, address detect,
 * and synchronous master transmit, behind a classic wishbone slave.
 * assumes rx_in is asynchronous to clk_sys; pins are resolved outside
 * from the output enables.
 */
`timescale 1ns/10ps
module usrt_top
    import usrt_pkg::*;
(
    // system
    input wire logic clk_sys,
    input wire logic reset_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial pins
    input wire logic rx_in,
    output logic tx_out,
    output logic tx_oe,
    output logic ck_out,
    output logic ck_oe,
    // interrupt
    output logic irq
);
    logic [7:0] rxsc_q;
    logic [7:0] txsc_q;
    logic [7:0] baud_q;
    logic [7:0] pena_q;
    logic [1:0] intc_q;
    logic [7:0] hold_q;
    logic hold_full_q;
    logic [8:0] tsr_q;
    logic [3:0] tx_bits_q;
    logic tx_busy_q;
    logic tx_empty_q;
    logic overrun_q;
    logic rx_s1_q;
    logic rx_s2_q;
    logic tick;
    logic baud_run;
    logic sync_mode;
    logic master;
    logic rx_enabled;
    logic tx_active;
    logic [1:0] fifo_cnt;
    logic [9:0] fifo_head;
    logic fifo_push;
    logic fifo_pop;
    logic [9:0] rx_word;
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] idx;
    logic load_tsr;
    logic ck_phase_q;

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } usrt_rx_state_t;
    usrt_rx_state_t rx_state_q;
    logic [3:0] rx_os_q;
    logic [3:0] rx_bits_q;
    logic [8:0] rx_sh_q;
    logic rx_done;
    logic rx_stop_bit;

    function automatic logic [7:0] wr_byte(input logic [7:0] old,
        input logic [7:0] val, input logic [7:0] mask);
        wr_byte = (old & ~mask) | (val & mask);
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign idx = wb_adr_i[9:2];
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign bus_rd = bus_req && !wb_we_i;
    assign sync_mode = txsc_q[TX_SYNC] && rxsc_q[RX_PORT_EN];
    assign master = sync_mode && txsc_q[TX_CLK_SRC];
    assign rx_enabled = rxsc_q[RX_CONT] || rxsc_q[RX_SINGLE];
    // in sync mode, receive enable suspends, but does not reset, the transmitter
    assign tx_active = txsc_q[TX_EN] && !(sync_mode && rx_enabled);
    assign baud_run = txsc_q[TX_EN] || rx_enabled;
    assign load_tsr = tx_active && hold_full_q && !tx_busy_q;

    usrt_baud u_baud (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(baud_run),
        .divisor(baud_q),
        .tick(tick)
    );

    // register writes
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            rxsc_q <= REG_RESET;
            txsc_q <= TXSC_RESET;
            baud_q <= REG_RESET;
            pena_q <= REG_RESET;
            intc_q <= 2'h0;
        end
        else
        begin
            if (bus_wr && idx == IDX_RXSC)
            begin
                rxsc_q <= wr_byte(rxsc_q, wb_dat_i[7:0], 8'hF8);
            end
            else if (rx_done && sync_mode)
            begin
                rxsc_q[RX_SINGLE] <= 1'b0;
            end
            if (bus_wr && idx == IDX_TXSC)
            begin
                txsc_q <= wr_byte(txsc_q, wb_dat_i[7:0], 8'hF5);
            end
            if (bus_wr && idx == IDX_BAUD)
            begin
                baud_q <= wb_dat_i[7:0];
            end
            if (bus_wr && idx == IDX_PENA)
            begin
                pena_q <= wb_dat_i[7:0];
            end
            if (bus_wr && idx == IDX_INTCTL)
            begin
                intc_q <= wb_dat_i[7:6];
            end
        end
    end

    // holding register; a write beats the transfer in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            hold_q <= 8'h00;
            hold_full_q <= 1'b0;
        end
        else if (bus_wr && idx == IDX_TXHOLD)
        begin
            hold_q <= wb_dat_i[7:0];
            hold_full_q <= 1'b1;
        end
        else if (load_tsr)
        begin
            hold_full_q <= 1'b0;
        end
    end

    // transmit empty flag follows the holding register only
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            tx_empty_q <= 1'b0;
        end
        else if (bus_wr && idx == IDX_TXHOLD)
        begin
            tx_empty_q <= 1'b0;
        end
        else if (txsc_q[TX_EN] && !hold_full_q)
        begin
            tx_empty_q <= 1'b1;
        end
    end

    // transmit shifter: data changes on the falling clock phase
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !txsc_q[TX_EN])
        begin
            tsr_q <= 9'h000;
            tx_bits_q <= 4'h0;
            tx_busy_q <= 1'b0;
            ck_phase_q <= 1'b0;
        end
        else if (load_tsr)
        begin
            tsr_q <= {txsc_q[TX_NINTH], hold_q};
            tx_bits_q <= txsc_q[TX_NINE] ? 4'h9 : 4'h8;
            tx_busy_q <= 1'b1;
            ck_phase_q <= 1'b0;
        end
        else if (tx_active && tx_busy_q && tick)
        begin
            ck_phase_q <= ~ck_phase_q;
            if (ck_phase_q)
            begin
                tsr_q <= {1'b0, tsr_q[8:1]};
                tx_bits_q <= tx_bits_q - 4'h1;
                tx_busy_q <= tx_bits_q != 4'h1;
            end
        end
    end

    // pins: clock out in master mode, data only while transmitting
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            tx_out <= 1'b1;
            tx_oe <= 1'b0;
            ck_out <= 1'b0;
            ck_oe <= 1'b0;
        end
        else
        begin
            tx_out <= tsr_q[0];
            tx_oe <= sync_mode && tx_active;
            ck_oe <= master && baud_run;
            ck_out <= tx_busy_q && tx_active && ck_phase_q;
        end
    end

    // receive path: sync the pin twice, 16 ticks per bit
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= rx_in;
            rx_s2_q <= rx_s1_q;
        end
    end

    assign rx_stop_bit = rx_s2_q;
    assign rx_done = rx_state_q == RX_STOP && tick && rx_os_q == 4'hF;
    assign rx_word = rxsc_q[RX_NINE] ? {!rx_stop_bit, rx_sh_q} :
        {!rx_stop_bit, 1'b0, rx_sh_q[8:1]};

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !rxsc_q[RX_CONT] || sync_mode)
        begin
            rx_state_q <= RX_IDLE;
            rx_os_q <= 4'h0;
            rx_bits_q <= 4'h0;
            rx_sh_q <= 9'h000;
        end
        else if (tick)
        begin
            rx_os_q <= rx_os_q + 4'h1;
            case (rx_state_q)
                RX_IDLE:
                begin
                    rx_os_q <= 4'h0;
                    if (!rx_s2_q)
                    begin
                        rx_state_q <= RX_START;
                    end
                end
                RX_START:
                begin
                    if (rx_os_q == 4'h7)
                    begin
                        rx_os_q <= 4'h0;
                        rx_bits_q <= rxsc_q[RX_NINE] ? 4'h9 : 4'h8;
                        rx_state_q <= rx_s2_q ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    if (rx_os_q == 4'hF)
                    begin
                        rx_sh_q <= {rx_s2_q, rx_sh_q[8:1]};
                        rx_bits_q <= rx_bits_q - 4'h1;
                        if (rx_bits_q == 4'h1)
                        begin
                            rx_state_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP:
                begin
                    if (rx_os_q == 4'hF)
                    begin
                        rx_state_q <= RX_IDLE;
                    end
                end
                default:
                begin
                    rx_state_q <= RX_IDLE;
                end
            endcase
        end
    end

    // address filter: ninth bit one is an address byte
    assign fifo_push = rx_done && !overrun_q && fifo_cnt != 2'h2 &&
        !(rxsc_q[RX_ADDR_DET] && rxsc_q[RX_NINE] &&
          !rx_sh_q[8]);
    assign fifo_pop = bus_rd && idx == IDX_RXDATA;

    usrt_rx_fifo #(
        .WIDTH(10)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clear(1'b0),
        .push(fifo_push),
        .wr_data(rx_word),
        .pop(fifo_pop),
        .rd_data(fifo_head),
        .count(fifo_cnt)
    );

    // overrun is sticky until continuous receive is cleared
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !rxsc_q[RX_CONT])
        begin
            overrun_q <= 1'b0;
        end
        else if (rx_done && fifo_cnt == 2'h2)
        begin
            overrun_q <= 1'b1;
        end
    end

    // bus answer one cycle after the request
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_rd)
            begin
                case (idx)
                    IDX_INTCTL: wb_dat_o[7:6] <= intc_q;
                    IDX_PFLAGS: wb_dat_o[7:0] <= {2'b00,
                        fifo_cnt != 2'h0, tx_empty_q, 4'h0};
                    IDX_RXSC: wb_dat_o[7:0] <= {rxsc_q[7:3],
                        fifo_head[9] && rxsc_q[RX_CONT], overrun_q,
                        fifo_head[8]};
                    IDX_TXHOLD: wb_dat_o[7:0] <= hold_q;
                    IDX_RXDATA: wb_dat_o[7:0] <= fifo_head[7:0];
                    IDX_PENA: wb_dat_o[7:0] <= pena_q;
                    IDX_TXSC: wb_dat_o[7:0] <= {txsc_q[7:2],
                        !tx_busy_q, txsc_q[0]};
                    IDX_BAUD: wb_dat_o[7:0] <= baud_q;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= intc_q[1] && intc_q[0] &&
                ((pena_q[PF_RX_FULL] && fifo_cnt != 2'h0) ||
                 (pena_q[PF_TX_EMPTY] && tx_empty_q));
        end
    end
endmodule

//--- testbench/usrt_top_props.sv
/*
 * usrt_top_props: bus handshake and pin checks on the top ports.
 * assumes a classic wishbone master that holds each request to ack.
 */
`timescale 1ns/10ps
module usrt_top_props
    import usrt_pkg::*;
(
    // system
    input wire logic clk_sys,
    input wire logic reset_n,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // serial pins and interrupt
    input wire logic rx_in,
    input wire logic tx_out,
    input wire logic tx_oe,
    input wire logic ck_out,
    input wire logic ck_oe,
    input wire logic irq
);
    logic [7:0] txsc_q;
    logic [7:0] rxsc_q;
    logic [7:0] ic_q;
    logic wr_ok;
    logic idle;
    logic ms_run;
    assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign idle = !(txsc_q[TX_EN] || rxsc_q[RX_CONT] || rxsc_q[RX_SINGLE]);
    assign ms_run = txsc_q[TX_EN] && txsc_q[TX_SYNC] && txsc_q[TX_CLK_SRC];
    // shadows lag the design by a cycle; single self-clear is not tracked
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            txsc_q <= TXSC_RESET;
            rxsc_q <= REG_RESET;
            ic_q <= REG_RESET;
        end
        else if (wr_ok)
        begin
            if (wb_adr_i[9:2] == IDX_TXSC)
                txsc_q <= wb_dat_i[7:0];
            if (wb_adr_i[9:2] == IDX_RXSC)
                rxsc_q <= wb_dat_i[7:0];
            if (wb_adr_i[9:2] == IDX_INTCTL)
                ic_q <= wb_dat_i[7:0];
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");
    property p_ack_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("request not acknowledged next cycle");
    property p_unmapped;
        wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'hFF |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_txsc_read;
        wb_ack_o && !wb_we_i && wb_adr_i[9:2] == IDX_TXSC
            |-> wb_dat_o[3] == 1'b0 && wb_dat_o[31:8] == 24'h0;
    endproperty
    a_txsc_read: assert property (p_txsc_read)
        else $error("transmit status unused bits not zero");
    property p_tx_abort;
        $fell(txsc_q[TX_EN]) && !rxsc_q[RX_CONT] && !rxsc_q[RX_SINGLE]
            |-> ##[1:3] !tx_oe && !ck_oe;
    endproperty
    a_tx_abort: assert property (p_tx_abort)
        else $error("pins not released after transmit disable");
    property p_rx_abort;
        $rose(rxsc_q[RX_CONT]) |-> ##[1:3] !tx_oe;
    endproperty
    a_rx_abort: assert property (p_rx_abort)
        else $error("data pin still driven while receiving");
    property p_clk_stays;
        $rose(rxsc_q[RX_CONT]) && ms_run |-> ##[1:3] ck_oe;
    endproperty
    a_clk_stays: assert property (p_clk_stays)
        else $error("clock pin released on receive abort");
    property p_brg_idle;
        idle [*3] |-> !ck_oe;
    endproperty
    a_brg_idle: assert property (p_brg_idle)
        else $error("shift clock driven with all enables clear");
    property p_master_clk;
        $fell(txsc_q[TX_CLK_SRC]) |-> ##[1:3] !ck_oe;
    endproperty
    a_master_clk: assert property (p_master_clk)
        else $error("clock driven without clock source select");
    property p_tx_needs_en;
        $rose(tx_oe) |-> txsc_q[TX_EN] && txsc_q[TX_SYNC];
    endproperty
    a_tx_needs_en: assert property (p_tx_needs_en)
        else $error("data pin driven without transmit enable");
    property p_irq_gate;
        !ic_q[IC_GLOBAL] [*2] |-> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised with global enable clear");
endmodule
bind usrt_top usrt_top_props chk_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe),
    .ck_out(ck_out), .ck_oe(ck_oe), .irq(irq)
);

//--- testbench/usrt_link_model.sv
/*
 * usrt_link_model: far-side partner; sends nine-bit async frames and
 * collects the bits clocked out by the master.
 * assumes the receive line has a pull-up and idles high.
 */
`timescale 1ns/10ps
module usrt_link_model #(
    parameter int BIT_NS = 640
)
(
    // pins from the block
    input wire logic tx_out,
    input wire logic tx_oe,
    input wire logic ck_out,
    input wire logic ck_oe,
    // pin to the block
    output logic rx_in
);
    logic [17:0] got;
    int cnt;
    initial
    begin
        rx_in = 1'b1;
        got = '0;
        cnt = 0;
    end
    // data changes on the falling edge, so the rising edge is safe
    always @(posedge ck_out)
    begin
        if (ck_oe && tx_oe && cnt < 18)
        begin
            got[cnt] = tx_out;
            cnt = cnt + 1;
        end
    end
    task clear;
        begin
            got = '0;
            cnt = 0;
        end
    endtask
    task send(input logic [8:0] w, input logic stop);
        int i;
        begin
            rx_in = 1'b0;
            #(BIT_NS);
            for (i = 0; i < 9; i++)
            begin
                rx_in = w[i];
                #(BIT_NS);
            end
            rx_in = stop;
            #(BIT_NS);
            rx_in = 1'b1;
            #(BIT_NS * 2);
        end
    endtask
endmodule

//--- testbench/usrt_top_bench.sv
/*
 * usrt_top_bench: self-checking bench for the serial port block.
 * assumes the link model and checker are compiled before it.
 */
`timescale 1ns/10ps
module usrt_top_bench
    import usrt_pkg::*;
();
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, rx_in, tx_out, tx_oe, ck_out, ck_oe, irq;
    int err_total = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    logic [7:0] rd, b0, b1;
    always #5 clk_sys = ~clk_sys;
    usrt_top dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe),
        .ck_out(ck_out), .ck_oe(ck_oe), .irq(irq)
    );
    usrt_link_model #(.BIT_NS(640)) link_u (
        .tx_out(tx_out), .tx_oe(tx_oe), .ck_out(ck_out), .ck_oe(ck_oe),
        .rx_in(rx_in)
    );
    task complete_run;
        begin
            $display("mismatches %0d of %0d checks", err_total, cmp_count);
            if (err_total == 0 && cmp_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
        begin
            cmp_count++;
            if (got !== exp)
            begin
                err_total++;
                $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
            end
        end
    endtask
    // one classic cycle; the slave's answer is awaited, never assumed
    task xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        begin
            n = 0;
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= {idx, 2'b00};
            wb_dat_i <= {24'h0, wd};
            @(posedge clk_sys);
            while (wb_ack_o !== 1'b1 && n < 50)
            begin
                @(posedge clk_sys);
                n++;
            end
            if (n >= 50)
                err_total++;
            rd = wb_dat_o[7:0];
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task rdchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        begin
            xfer(1'b0, idx, 8'h00);
            chk(nm, exp, rd);
        end
    endtask
    task wait_bits(input int n);
        int k;
        begin
            k = 0;
            while (link_u.cnt < n && k < 3000)
            begin
                @(posedge clk_sys);
                k++;
            end
            // a link that never clocks out enough bits is a failure
            if (k >= 3000)
                err_total++;
        end
    endtask
    always @(posedge clk_sys)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            err_total++;
            complete_run;
        end
    end
    initial
    begin
        void'($urandom(32'h8399));
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rdchk("txsc reset", IDX_TXSC, TXSC_RESET);
        rdchk("flags reset", IDX_PFLAGS, REG_RESET);
        rdchk("unmapped", 8'hFF, 8'h00);
        xfer(1'b1, IDX_TXSC, 8'h00);
        rdchk("shifter empty ro", IDX_TXSC, 8'h02);
        // sync master: holding loaded before the enable
        xfer(1'b1, IDX_BAUD, 8'h03);
        xfer(1'b1, IDX_RXSC, 8'h80);
        xfer(1'b1, IDX_TXSC, 8'h90);
        link_u.clear();
        xfer(1'b1, IDX_TXHOLD, b0);
        chk("idle clock", 1'b0, ck_oe);
        xfer(1'b1, IDX_TXSC, 8'hB0);
        chk("master clock", 1'b1, ck_oe);
        xfer(1'b1, IDX_TXHOLD, b1);
        rdchk("holding full", IDX_PFLAGS, 8'h00);
        wait_bits(16);
        chk("word pair", {2'b00, b1, b0}, link_u.got);
        rdchk("tx empty", IDX_PFLAGS, 8'h10);
        rdchk("shifter idle", IDX_TXSC, 8'hB2);
        // ninth bit written before the data byte
        xfer(1'b1, IDX_TXSC, 8'hF1);
        link_u.clear();
        xfer(1'b1, IDX_TXHOLD, b0);
        wait_bits(9);
        chk("nine bit", {9'h000, 1'b1, b0}, link_u.got);
        // abort by receive enable, then by clearing transmit enable
        xfer(1'b1, IDX_TXSC, 8'hB0);
        xfer(1'b1, IDX_TXHOLD, b1);
        xfer(1'b1, IDX_RXSC, 8'h90);
        rdchk("baud", IDX_BAUD, 8'h03);
        chk("data released", 1'b0, tx_oe);
        chk("clock kept", 1'b1, ck_oe);
        xfer(1'b1, IDX_RXSC, 8'h80);
        xfer(1'b1, IDX_TXSC, 8'h90);
        rdchk("baud", IDX_BAUD, 8'h03);
        chk("data off", 1'b0, tx_oe);
        chk("clock off", 1'b0, ck_oe);
        // single receive only after transmit enable is cleared
        xfer(1'b1, IDX_RXSC, 8'hA0);
        chk("single rx data off", 1'b0, tx_oe);
        chk("single rx clock", 1'b1, ck_oe);
        // async receive with address detect
        b1 = 8'($urandom);
        xfer(1'b1, IDX_TXSC, 8'h00);
        xfer(1'b1, IDX_INTCTL, 8'hC0);
        xfer(1'b1, IDX_PENA, 8'h20);
        xfer(1'b1, IDX_RXSC, 8'hD8);
        link_u.send({1'b0, b1}, 1'b1);
        xfer(1'b0, IDX_PFLAGS, 8'h00);
        chk("data filtered", 1'b0, rd[PF_RX_FULL]);
        link_u.send({1'b1, b0}, 1'b1);
        xfer(1'b0, IDX_PFLAGS, 8'h00);
        chk("address kept", 1'b1, rd[PF_RX_FULL]);
        chk("irq on", 1'b1, irq);
        xfer(1'b1, IDX_PENA, 8'h00);
        chk("irq masked", 1'b0, irq);
        rdchk("status", IDX_RXSC, 8'hD9);
        rdchk("address", IDX_RXDATA, b0);
        // data passes once detect is off; framing error and overrun
        xfer(1'b1, IDX_RXSC, 8'hD0);
        link_u.send({1'b0, b1}, 1'b0);
        link_u.send({1'b1, b0}, 1'b1);
        link_u.send({1'b0, b1}, 1'b1);
        rdchk("status 1", IDX_RXSC, 8'hD6);
        rdchk("word 1", IDX_RXDATA, b1);
        rdchk("status 2", IDX_RXSC, 8'hD3);
        rdchk("word 2", IDX_RXDATA, b0);
        xfer(1'b0, IDX_PFLAGS, 8'h00);
        chk("fifo empty", 1'b0, rd[PF_RX_FULL]);
        xfer(1'b1, IDX_RXSC, 8'hC0);
        // fifo is empty: the ninth bit of the last word read stays visible
        rdchk("overrun cleared", IDX_RXSC, 8'hC1);
        complete_run;
    end
endmodule
